// *** logic/pfg_regs.vh ***
`ifndef PFG_REGS_VH
`define PFG_REGS_VH

// ----------------------------------------------------------------------
// Register map of the fault guard and wide access block.
// ----------------------------------------------------------------------
`define PFG_ADDR_W          4
`define PFG_OFF_COUNT_LO    4'h0
`define PFG_OFF_CMP_A_LO    4'h1
`define PFG_OFF_CMP_B_LO    4'h2
`define PFG_OFF_CMP_C_LO    4'h3
`define PFG_OFF_CMP_D_LO    4'h4
`define PFG_OFF_HIGH_LATCH  4'h5
`define PFG_OFF_CTRL_A      4'h6
`define PFG_OFF_CTRL_D      4'h7
`define PFG_OFF_STATUS      4'h8
`define PFG_OFF_PORT_B      4'h9

// ----------------------------------------------------------------------
// Field positions of timer_ctrl_d and the status register.
// ----------------------------------------------------------------------
`define PFG_CD_GUARD_EN     0
`define PFG_CD_IRQ_EN       1
`define PFG_CD_SRC_CMP      2
`define PFG_CD_FILT_EN      3
`define PFG_CD_EDGE_RISE    4
`define PFG_ST_EVENT_FLAG   0

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define PFG_RST_WIDE        10'h000
`define PFG_RST_LATCH       2'h0
`define PFG_RST_CTRL_A      8'h00
`define PFG_RST_CTRL_D      5'h00
`define PFG_RST_PORT_B      4'h0

// ----------------------------------------------------------------------
// Timing counts.
// ----------------------------------------------------------------------
`define PFG_FILT_SAMPLES    4

`endif

// *** logic/pfg_top.v ***
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "pfg_regs.vh"

// How it works
// - Enabled guard trips on selected trigger edge.
// - Trip clears output modes, pins show port.
// - Trip clears guard enable in same cycle.
// - Trip with irq enable raises interrupt request.
// - Pin source default, comparator when selected.
// - Source changes may trip; software clears flag.
// - Both triggers synchronised, shared edge detector.
// - Filter output moves after four equal samples.
// - Filter active only when filter bit set.
// - Filter adds exactly four cycles of delay.
// - Filter samples every system clock cycle.
// - Port driving the pin also trips.
// - Count and compares accessed as byte pairs.
// - One shared two-bit high latch.
// - Only low-byte access or count_in moves wide registers.
// - Low write loads latch and byte together.
// - Low read copies top bits into latch.
// - Latch keeps value after low write.
// - Zero output mode passes port bit.
module pfg_top #(
  parameter NUM_CH = 4
) (
  input  wire                   clk_sys,
  input  wire                   rst,
  input  wire [`PFG_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [7:0]             reg_rdata_ff,
  input  wire                   ext_irq_pin,
  input  wire                   comparator_result,
  input  wire [NUM_CH-1:0]      waveform_out,
  input  wire [9:0]             count_in,
  input  wire                   count_in_valid,
  output reg  [NUM_CH-1:0]      pwm_pin_ff,
  output reg  [9:0]             count_value_ff,
  output reg  [9:0]             compare_value_a_ff,
  output reg  [9:0]             compare_value_b_ff,
  output reg  [9:0]             compare_value_c_ff,
  output reg  [9:0]             compare_value_d_ff,
  output reg  [7:0]             compare_output_mode_bits_ff,
  output reg                    fault_irq_ff
);

  // --------------------------------------------------------------------
  // Register state.
  // --------------------------------------------------------------------
  reg  [1:0] shared_high_byte_latch_ff;  // Two upper bits of wide accesses.
  reg  [4:0] timer_ctrl_d_ff;            // Fault guard control bits.
  reg        fault_event_flag_ff;        // Sticky event flag, set by any qualifying edge.
  reg  [3:0] port_b_output_bits_ff;      // Port values shown when disconnected.

  // Field aliases of the control register.
  wire fault_guard_enable             = timer_ctrl_d_ff[`PFG_CD_GUARD_EN];
  wire fault_irq_enable               = timer_ctrl_d_ff[`PFG_CD_IRQ_EN];
  wire fault_source_comparator_select = timer_ctrl_d_ff[`PFG_CD_SRC_CMP];
  wire fault_filter_enable            = timer_ctrl_d_ff[`PFG_CD_FILT_EN];
  wire fault_edge_rising              = timer_ctrl_d_ff[`PFG_CD_EDGE_RISE];

  // Decoded strobes.
  wire wr_count  = reg_wr && (reg_addr == `PFG_OFF_COUNT_LO);
  wire wr_cmp_a  = reg_wr && (reg_addr == `PFG_OFF_CMP_A_LO);
  wire wr_cmp_b  = reg_wr && (reg_addr == `PFG_OFF_CMP_B_LO);
  wire wr_cmp_c  = reg_wr && (reg_addr == `PFG_OFF_CMP_C_LO);
  wire wr_cmp_d  = reg_wr && (reg_addr == `PFG_OFF_CMP_D_LO);
  wire wr_latch  = reg_wr && (reg_addr == `PFG_OFF_HIGH_LATCH);
  wire wr_ctrl_a = reg_wr && (reg_addr == `PFG_OFF_CTRL_A);
  wire wr_ctrl_d = reg_wr && (reg_addr == `PFG_OFF_CTRL_D);
  wire wr_status = reg_wr && (reg_addr == `PFG_OFF_STATUS);
  wire wr_port   = reg_wr && (reg_addr == `PFG_OFF_PORT_B);

  // Wide value formed from the latch and the written low byte.
  wire [9:0] wide_wdata = {shared_high_byte_latch_ff, reg_wdata};

  // --------------------------------------------------------------------
  // Trigger input synchronisers.
  // --------------------------------------------------------------------
  reg pin_meta_ff;   // First stage, read only by the second stage.
  reg pin_sync_ff;   // Pin level in the clock domain.
  reg cmp_meta_ff;   // First stage, read only by the second stage.
  reg cmp_sync_ff;   // Comparator level in the clock domain.

  // Both sources pass two flip-flops; the pin is sampled as it stands,
  // so a level driven onto it by the port counts like any other.
  always @(posedge clk_sys) begin
    if (rst) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
      cmp_meta_ff <= 1'b0;
      cmp_sync_ff <= 1'b0;
    end else begin
      pin_meta_ff <= ext_irq_pin;
      pin_sync_ff <= pin_meta_ff;
      cmp_meta_ff <= comparator_result;
      cmp_sync_ff <= cmp_meta_ff;
    end
  end

  // Source select: pin by default, comparator when chosen.
  wire src_level = fault_source_comparator_select ? cmp_sync_ff : pin_sync_ff;

  // --------------------------------------------------------------------
  // Noise filter.
  // --------------------------------------------------------------------
  reg  [`PFG_FILT_SAMPLES-2:0] filt_hist_ff;  // Previous samples of the source.
  reg                          filt_out_ff;   // Filtered level.
  reg                          nxt_filt_out;

  // The current sample and the three stored ones make four samples.
  wire filt_all_one  = src_level && (&filt_hist_ff);
  wire filt_all_zero = !src_level && !(|filt_hist_ff);

  // The output moves only when all four samples agree on a new level.
  always @* begin
    nxt_filt_out = filt_out_ff;
    if (filt_all_one) begin
      nxt_filt_out = 1'b1;
    end else if (filt_all_zero) begin
      nxt_filt_out = 1'b0;
    end
  end

  // The filter runs every system cycle regardless of any prescaler.
  always @(posedge clk_sys) begin
    if (rst) begin
      filt_hist_ff <= {(`PFG_FILT_SAMPLES-1){1'b0}};
      filt_out_ff  <= 1'b0;
    end else begin
      filt_hist_ff <= {filt_hist_ff[`PFG_FILT_SAMPLES-3:0], src_level};
      filt_out_ff  <= nxt_filt_out;
    end
  end

  // The filtered path is four registers longer than the direct one.
  wire det_level = fault_filter_enable ? filt_out_ff : src_level;

  // --------------------------------------------------------------------
  // Edge detector and trip decision.
  // --------------------------------------------------------------------
  reg det_prev_ff;  // Level seen by the detector one cycle ago.

  // Remembers the detector input to find level changes.
  always @(posedge clk_sys) begin
    if (rst) begin
      det_prev_ff <= 1'b0;
    end else begin
      det_prev_ff <= det_level;
    end
  end

  // A qualifying edge follows the direction setting; changing the
  // source or filter setting can itself make one.
  wire edge_rise = det_level && !det_prev_ff;
  wire edge_fall = !det_level && det_prev_ff;
  wire edge_hit  = fault_edge_rising ? edge_rise : edge_fall;
  wire trip      = fault_guard_enable && edge_hit;

  // --------------------------------------------------------------------
  // Control, status and port registers.
  // --------------------------------------------------------------------
  reg [4:0] nxt_ctrl_d;
  reg [7:0] nxt_ctrl_a;
  reg       nxt_flag;

  // A trip overrides a software write in the same cycle.
  always @* begin
    nxt_ctrl_a = compare_output_mode_bits_ff;
    nxt_ctrl_d = timer_ctrl_d_ff;
    if (wr_ctrl_a) begin
      nxt_ctrl_a = reg_wdata;
    end
    if (wr_ctrl_d) begin
      nxt_ctrl_d = reg_wdata[4:0];
    end
    if (trip) begin
      nxt_ctrl_a = 8'h00;
      nxt_ctrl_d[`PFG_CD_GUARD_EN] = 1'b0;
    end
  end

  // Flag: write one clears, a detected edge sets and wins over the clear.
  always @* begin
    nxt_flag = fault_event_flag_ff;
    if (wr_status && reg_wdata[`PFG_ST_EVENT_FLAG]) begin
      nxt_flag = 1'b0;
    end
    if (edge_hit) begin
      nxt_flag = 1'b1;
    end
  end

  // Holds the control and status registers.
  always @(posedge clk_sys) begin
    if (rst) begin
      compare_output_mode_bits_ff <= `PFG_RST_CTRL_A;
      timer_ctrl_d_ff             <= `PFG_RST_CTRL_D;
      fault_event_flag_ff         <= 1'b0;
      port_b_output_bits_ff       <= `PFG_RST_PORT_B;
      fault_irq_ff                <= 1'b0;
    end else begin
      compare_output_mode_bits_ff <= nxt_ctrl_a;
      timer_ctrl_d_ff             <= nxt_ctrl_d;
      fault_event_flag_ff         <= nxt_flag;
      if (wr_port) begin
        port_b_output_bits_ff <= reg_wdata[3:0];
      end
      // Request stays up while the event flag is set and irq enable is set.
      fault_irq_ff <= (nxt_flag || trip) && nxt_ctrl_d[`PFG_CD_IRQ_EN];
    end
  end

  // --------------------------------------------------------------------
  // Pin multiplexer.
  // --------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_pin
      // Zero mode bits hand the pin to the port register.
      always @(posedge clk_sys) begin
        if (rst) begin
          pwm_pin_ff[ch] <= 1'b0;
        end else if (nxt_ctrl_a[2*ch+1 -: 2] == 2'b00) begin
          pwm_pin_ff[ch] <= port_b_output_bits_ff[ch];
        end else begin
          pwm_pin_ff[ch] <= waveform_out[ch];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Wide registers and the shared latch.
  // --------------------------------------------------------------------
  wire rd_count = reg_rd && (reg_addr == `PFG_OFF_COUNT_LO);
  wire rd_cmp_a = reg_rd && (reg_addr == `PFG_OFF_CMP_A_LO);
  wire rd_cmp_b = reg_rd && (reg_addr == `PFG_OFF_CMP_B_LO);
  wire rd_cmp_c = reg_rd && (reg_addr == `PFG_OFF_CMP_C_LO);
  wire rd_cmp_d = reg_rd && (reg_addr == `PFG_OFF_CMP_D_LO);

  // Only low-byte accesses and count_in (count only) move whole values; software pairs a latch
  // write before the low write and a low read before the latch read,
  // masking interrupts around each pair.
  always @(posedge clk_sys) begin
    if (rst) begin
      count_value_ff     <= `PFG_RST_WIDE;
      compare_value_a_ff <= `PFG_RST_WIDE;
      compare_value_b_ff <= `PFG_RST_WIDE;
      compare_value_c_ff <= `PFG_RST_WIDE;
      compare_value_d_ff <= `PFG_RST_WIDE;
    end else begin
      if (wr_count) begin
        count_value_ff <= wide_wdata;
      end else if (count_in_valid) begin
        count_value_ff <= count_in;
      end
      if (wr_cmp_a) begin
        compare_value_a_ff <= wide_wdata;
      end
      if (wr_cmp_b) begin
        compare_value_b_ff <= wide_wdata;
      end
      if (wr_cmp_c) begin
        compare_value_c_ff <= wide_wdata;
      end
      if (wr_cmp_d) begin
        compare_value_d_ff <= wide_wdata;
      end
    end
  end

  // The single latch is loaded by a direct write or by a low-byte read,
  // and a low-byte write leaves it untouched for reuse.
  always @(posedge clk_sys) begin
    if (rst) begin
      shared_high_byte_latch_ff <= `PFG_RST_LATCH;
    end else if (wr_latch) begin
      shared_high_byte_latch_ff <= reg_wdata[1:0];
    end else if (rd_count) begin
      shared_high_byte_latch_ff <= count_value_ff[9:8];
    end else if (rd_cmp_a) begin
      shared_high_byte_latch_ff <= compare_value_a_ff[9:8];
    end else if (rd_cmp_b) begin
      shared_high_byte_latch_ff <= compare_value_b_ff[9:8];
    end else if (rd_cmp_c) begin
      shared_high_byte_latch_ff <= compare_value_c_ff[9:8];
    end else if (rd_cmp_d) begin
      shared_high_byte_latch_ff <= compare_value_d_ff[9:8];
    end
  end

  // --------------------------------------------------------------------
  // Read data.
  // --------------------------------------------------------------------
  reg [7:0] nxt_rdata;

  // Selects the byte returned one cycle after a read strobe.
  always @* begin
    case (reg_addr)
      `PFG_OFF_COUNT_LO:   nxt_rdata = count_value_ff[7:0];
      `PFG_OFF_CMP_A_LO:   nxt_rdata = compare_value_a_ff[7:0];
      `PFG_OFF_CMP_B_LO:   nxt_rdata = compare_value_b_ff[7:0];
      `PFG_OFF_CMP_C_LO:   nxt_rdata = compare_value_c_ff[7:0];
      `PFG_OFF_CMP_D_LO:   nxt_rdata = compare_value_d_ff[7:0];
      `PFG_OFF_HIGH_LATCH: nxt_rdata = {6'h00, shared_high_byte_latch_ff};
      `PFG_OFF_CTRL_A:     nxt_rdata = compare_output_mode_bits_ff;
      `PFG_OFF_CTRL_D:     nxt_rdata = {3'h0, timer_ctrl_d_ff};
      `PFG_OFF_STATUS:     nxt_rdata = {7'h00, fault_event_flag_ff};
      `PFG_OFF_PORT_B:     nxt_rdata = {4'h0, port_b_output_bits_ff};
      default:             nxt_rdata = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe, zero otherwise.
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

endmodule

// *** tb/pfg_top_chk.sv ***
`timescale 1ns/1ps
// ----
// Checker on the ports of pfg_top.
// ----
module pfg_chk #(
  parameter NUM_CH = 4
) (
  input wire              clk_sys,
  input wire              rst,
  input wire              reg_wr,
  input wire              reg_rd,
  input wire [3:0]        reg_addr,
  input wire [7:0]        reg_wdata,
  input wire [7:0]        reg_rdata_ff,
  input wire [7:0]        compare_output_mode_bits_ff,
  input wire [NUM_CH-1:0] waveform_out,
  input wire [NUM_CH-1:0] pwm_pin_ff,
  input wire [9:0]        compare_value_a_ff,
  input wire [9:0]        compare_value_b_ff,
  input wire [9:0]        compare_value_c_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  reg     [NUM_CH-1:0] wf_q;     // Waveform seen one edge earlier.
  reg     [NUM_CH-1:0] bad_pin;  // Channels whose pin left its waveform.
  integer              n;
  // Delay the waveform to line up with the registered pins.
  always @(posedge clk_sys) begin
    wf_q <= waveform_out;
  end
  // Flag connected channels whose pin does not follow the waveform.
  always @* begin
    bad_pin = {NUM_CH{1'b0}};
    for (n = 0; n < NUM_CH; n = n + 1) begin
      bad_pin[n] = (compare_output_mode_bits_ff[2*n +: 2] != 2'h0) && (pwm_pin_ff[n] != wf_q[n]);
    end
  end
  sequence s_wr(a);
    reg_wr && reg_addr == a;
  endsequence
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_pin_follow: assert property (bad_pin == {NUM_CH{1'b0}})
    else $error("connected pin does not follow waveform");
  a_low_write: assert property (s_wr(4'h1)
    |=> compare_value_a_ff[7:0] == $past(reg_wdata))
    else $error("low write did not load low byte");
  a_wide_hold: assert property (!(reg_wr && reg_addr == 4'h1)
    |=> $stable(compare_value_a_ff))
    else $error("wide register moved without low write");
  a_mode_source: assert property (!$past(reg_wr && reg_addr == 4'h6)
    && $changed(compare_output_mode_bits_ff) |-> compare_output_mode_bits_ff == 8'h00)
    else $error("mode bits changed other than by write or trip");
  a_wide_write: assert property (s_wr(4'h5) ##2 s_wr(4'h2)
    |=> {6'h00, compare_value_b_ff[9:8]} == $past(reg_wdata, 3))
    else $error("wide write upper bits wrong");
  a_latch_reuse: assert property (s_wr(4'h5) ##2 s_wr(4'h2) ##2 s_wr(4'h3)
    |=> {6'h00, compare_value_c_ff[9:8]} == $past(reg_wdata, 5))
    else $error("latch lost value after low write");
  a_low_read: assert property (s_rd(4'h1) |=> reg_rdata_ff == compare_value_a_ff[7:0])
    else $error("low read data wrong");
  a_wide_read: assert property (s_rd(4'h1) ##2 s_rd(4'h5)
    |=> reg_rdata_ff == {6'h00, compare_value_a_ff[9:8]})
    else $error("latch read after low read wrong");
endmodule

bind pfg_top pfg_chk #(.NUM_CH(NUM_CH)) u_chk (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata_ff, .compare_output_mode_bits_ff, .waveform_out, .pwm_pin_ff,
  .compare_value_a_ff, .compare_value_b_ff, .compare_value_c_ff);

// *** tb/pfg_cpu.sv ***
`timescale 1ns/1ps
// ----
// CPU side of the byte bus; one access at a time, no interrupts between pairs.
// ----
module pfg_cpu (
  input  wire       clk_sys,
  output reg  [3:0] reg_addr,
  output reg  [7:0] reg_wdata,
  output reg        reg_wr,
  output reg        reg_rd,
  input  wire [7:0] reg_rdata_ff
);
  // Idle bus at time zero.
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One write cycle; released lines show the inverse value.
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      #1;
    end
  endtask
  // One read cycle; data taken in the answer cycle.
  task rd(input [3:0] a, output [7:0] d);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata_ff;
    end
  endtask
  // Latch first, then low byte; pairs never interleave.
  task wide_wr(input [3:0] a, input [9:0] v);
    begin
      wr(4'h5, {6'h00, v[9:8]});
      wr(a, v[7:0]);
    end
  endtask
  // Low byte first, then latch.
  task wide_rd(input [3:0] a, output [7:0] lo, output [7:0] hi);
    begin
      rd(a, lo);
      rd(4'h5, hi);
    end
  endtask
endmodule

// *** tb/pwm_fault_guard_and_wide_access_bench.sv ***
`timescale 1ns/1ps
// ----
// Bench: wide access and fault guard against an integer model.
// ----
module pwm_fault_guard_and_wide_access_bench;
  reg        clk_sys, rst, ext_irq_pin, comparator_result, count_in_valid;
  reg  [3:0] waveform_out, wv;
  reg  [9:0] count_in;
  reg  [7:0] lo, hi, port_b;
  wire [3:0] reg_addr, pwm_pin_ff;
  wire [7:0] reg_wdata, reg_rdata_ff, mode_bits;
  wire       reg_wr, reg_rd, fault_irq_ff;
  wire [9:0] wide [0:4];
  integer    miscompares, total_checks, seed, i, n0, n1;
  integer    mdl [0:4];  // Model of the five wide registers.
  pfg_cpu u_cpu (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff);
  pfg_top #(.NUM_CH(4)) u_dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_ff, .ext_irq_pin, .comparator_result, .waveform_out, .count_in,
    .count_in_valid, .pwm_pin_ff, .count_value_ff(wide[0]), .compare_value_a_ff(wide[1]),
    .compare_value_b_ff(wide[2]), .compare_value_c_ff(wide[3]),
    .compare_value_d_ff(wide[4]), .compare_output_mode_bits_ff(mode_bits), .fault_irq_ff);
  // Compare one value and count it.
  task chk(input [8*10:1] name, input [15:0] seen, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD %0s exp %h seen %h", name, exp, seen);
      end
    end
  endtask
  // Print the counts and the verdict, then stop.
  task print_verdict;
    begin
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // Count edges until the interrupt request rises, bounded.
  task wait_irq(output integer n);
    begin
      n = 0;
      while (fault_irq_ff !== 1'b1 && n < 40) begin
        @(posedge clk_sys);
        #1 n = n + 1;
      end
      if (n >= 40) begin
        miscompares = miscompares + 1;
        disable scenarios;
      end
    end
  endtask
  // Connect all channels, set control, let sources settle, clear flag.
  task arm(input [7:0] ctrl);
    begin
      u_cpu.wr(4'h6, 8'hff);
      u_cpu.wr(4'h7, ctrl);
      repeat (8) @(posedge clk_sys);
      u_cpu.wr(4'h8, 8'h01);
      chk("irq clear", fault_irq_ff, 16'h0);
    end
  endtask
  // Judge the outcome of one trigger edge; a trip clears the guard bit and the mode bits.
  task judge(input t, input [7:0] ctrl);
    begin
      u_cpu.rd(4'h7, lo);
      chk("ctrl d", lo, t ? (ctrl & 8'hfe) : ctrl);
      chk("mode", mode_bits, t ? 8'h00 : 8'hff);
      chk("pins", pwm_pin_ff, t ? port_b[3:0] : wv);
      u_cpu.rd(4'h8, lo);
      chk("flag set", lo, 8'h01);
      u_cpu.wr(4'h8, 8'h01);
      u_cpu.rd(4'h8, lo);
      chk("flag clr", lo, 8'h00);
      chk("irq off", fault_irq_ff, 16'h0);
    end
  endtask
  // Free running 200 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Main sequence.
  initial begin
    seed = 28;
    miscompares = 0;
    total_checks = 0;
    rst = 1'b1;
    ext_irq_pin = 1'b0;
    comparator_result = 1'b0;
    count_in_valid = 1'b0;
    waveform_out = 4'h0;
    count_in = 10'h000;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    begin : scenarios
    for (i = 0; i <= 10; i = i + 1) begin
      u_cpu.rd(i[3:0], lo);
      chk("reset rd", lo, 8'h00);
    end
    for (i = 0; i < 5; i = i + 1) begin
      mdl[i] = $random(seed) & 10'h3ff;
      u_cpu.wide_wr(i[3:0], mdl[i][9:0]);
      chk("wide wr", wide[i], mdl[i][9:0]);
    end
    for (i = 0; i < 5; i = i + 1) begin
      u_cpu.wide_rd(i[3:0], lo, hi);
      chk("wide lo", lo, mdl[i][7:0]);
      chk("wide hi", hi, mdl[i][9:8]);
    end
    $display("test wide access done");
    u_cpu.wr(4'h5, 8'h02);
    for (i = 0; i < 5; i = i + 1) begin
      chk("latch only", wide[i], mdl[i][9:0]);
    end
    u_cpu.wr(4'h2, 8'h5a);
    u_cpu.wr(4'h3, 8'ha5);
    chk("reuse b", wide[2], 10'h25a);
    chk("reuse c", wide[3], 10'h2a5);
    n0 = $random(seed);
    @(posedge clk_sys);
    count_in <= n0[9:0];
    count_in_valid <= 1'b1;
    @(posedge clk_sys);
    count_in_valid <= 1'b0;
    #1 chk("count in", wide[0], n0[9:0]);
    $display("test latch done");
    port_b = $random(seed) & 8'h0f;
    wv = ~port_b[3:0];
    u_cpu.wr(4'h9, port_b);
    u_cpu.wr(4'h6, 8'hff);
    @(posedge clk_sys);
    waveform_out <= wv;
    repeat (2) @(posedge clk_sys);
    #1 chk("pin wave", pwm_pin_ff, wv);
    arm(8'h13);
    @(posedge clk_sys);
    ext_irq_pin <= 1'b1;
    wait_irq(n0);
    judge(1'b1, 8'h13);
    arm(8'h1f);
    @(posedge clk_sys);
    comparator_result <= 1'b1;
    repeat (3) @(posedge clk_sys);
    comparator_result <= 1'b0;
    repeat (12) @(posedge clk_sys);
    #1 chk("glitch", fault_irq_ff, 16'h0);
    @(posedge clk_sys);
    comparator_result <= 1'b1;
    wait_irq(n1);
    chk("filt lag", n1, n0 + 4);
    judge(1'b1, 8'h1f);
    arm(8'h02);
    @(posedge clk_sys);
    ext_irq_pin <= 1'b0;
    wait_irq(n1);
    judge(1'b0, 8'h02);
    $display("test fault guard done");
    end
    print_verdict;
  end
endmodule
